// *** bench/system_clock_divider_select_properties.sv ***
// Checker for clock select, wake gate and timer strobes.
// Assumes binding to the top module; ticks are cycle enables.
`timescale 1ns/1ps
module system_clock_divider_select_properties #(
    parameter DIV_WIDTH = 12,
    parameter CNT_WIDTH = 8
) (
    input wire                 clk_sys,
    input wire                 rst,
    input wire [7:0]           reg_addr,
    input wire [7:0]           reg_wdata,
    input wire                 reg_we,
    input wire                 reg_re,
    input wire [7:0]           reg_rdata_q,
    input wire                 main_osc_tick,
    input wire                 sub_osc_tick,
    input wire                 osc_sub_select,
    input wire                 cpu_clk_en_q,
    input wire                 bt_clk_en_q,
    input wire [DIV_WIDTH-1:0] tc_prescale,
    input wire [CNT_WIDTH-1:0] bt_count_q,
    input wire                 wake_event,
    input wire                 wake_irq_req_q,
    input wire                 wake_irq_enable
);
    reg [1:0] sel_q;
    wire tick = osc_sub_select ? sub_osc_tick : main_osc_tick;
    wire wr_cc = reg_we && reg_addr == 8'hd4;
    wire wr_bt = reg_we && reg_addr == 8'hd3;
    always @(posedge clk_sys) begin
        if (rst)
            sel_q <= 2'h0;
        else if (wr_cc)
            sel_q <= reg_wdata[4:3];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_values: assert property ($past(rst) |-> wake_irq_enable && reg_rdata_q == 8'h00
        && !cpu_clk_en_q && !bt_clk_en_q && bt_count_q == 0 && tc_prescale == 0)
        else $error("reset values");
    a_wake_gate: assert property (!$past(rst) |->
        wake_irq_req_q == $past(wake_event && wake_irq_enable)) else $error("wake gate");
    a_wake_bit_write: assert property (wr_cc |=>
        wake_irq_enable == !$past(reg_wdata[7])) else $error("wake enable bit");
    a_counter_clear: assert property (wr_bt && reg_wdata[1] |=>
        bt_count_q == 0) else $error("counter clear");
    a_divider_clear: assert property (wr_bt && reg_wdata[0] |=>
        tc_prescale == 0) else $error("divider clear");
    a_bt_div_clear: assert property (wr_bt && reg_wdata[0] |=>
        (!bt_clk_en_q) [*8]) else $error("basic timer divider clear");
    a_strobe_read_zero: assert property (reg_re && reg_addr == 8'hd3 |=>
        reg_rdata_q[1:0] == 2'h0) else $error("strobe bits read");
    a_unused_bits: assert property (reg_re && reg_addr == 8'hd4 |=>
        (reg_rdata_q & 8'h67) == 8'h00) else $error("unused bits read");
    a_div1_follow: assert property (sel_q == 2'h3 |=>
        cpu_clk_en_q == $past(tick)) else $error("undivided clock");
    a_pulse_tick: assert property (!$past(rst) && cpu_clk_en_q |->
        $past(tick)) else $error("pulse without tick");
endmodule
bind system_clock_divider_select system_clock_divider_select_properties #(
    .DIV_WIDTH(DIV_WIDTH), .CNT_WIDTH(CNT_WIDTH)) checker_inst (.clk_sys, .rst,
    .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_q, .main_osc_tick,
    .sub_osc_tick, .osc_sub_select, .cpu_clk_en_q, .bt_clk_en_q, .tc_prescale, .bt_count_q,
    .wake_event, .wake_irq_req_q, .wake_irq_enable);

// *** bench/system_clock_divider_select_test.sv ***
// Testbench for clock select, wake gate and timer strobes.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module system_clock_divider_select_test;
    reg clk_sys = 0, rst = 1, reg_we = 0, reg_re = 0, wake_event = 0;
    reg main_osc_tick = 0, sub_osc_tick = 0, osc_sub_select = 0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
    wire [7:0] reg_rdata_q, bt_count_q;
    wire [11:0] tc_prescale;
    wire cpu_clk_en_q, bt_clk_en_q, wake_irq_req_q, wake_irq_enable;
    int n_mismatch = 0, check_count = 0, c;
    always #2.5 clk_sys = ~clk_sys;
    system_clock_divider_select #(.DIV_WIDTH(12), .CNT_WIDTH(8))
        system_clock_divider_select_inst (.clk_sys, .rst, .reg_addr, .reg_wdata,
        .reg_we, .reg_re, .reg_rdata_q, .main_osc_tick, .sub_osc_tick,
        .osc_sub_select, .cpu_clk_en_q, .bt_clk_en_q, .tc_prescale, .bt_count_q,
        .wake_event, .wake_irq_req_q, .wake_irq_enable);
    // ---
    // Bus and check tasks
    // ---
    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_we = 1;
        step(1);
        reg_we = 0;
        step(1);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        reg_addr = a;
        reg_re = 1;
        step(1);
        reg_re = 0;
        chk("rdata", e, reg_rdata_q);
        step(1);
    endtask
    task count_pulses(output int n);
        n = 0;
        repeat (64) begin
            step(1);
            if (cpu_clk_en_q === 1'b1)
                n++;
        end
    endtask
    function int exp_pulses(input [1:0] s);
        return s == 0 ? 4 : s == 1 ? 8 : s == 2 ? 32 : 64;
    endfunction
    function int exp_bt_log2(input [1:0] s);
        return s == 0 ? 12 : s == 1 ? 10 : s == 2 ? 7 : 4;
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #150000;
        n_mismatch++;
        final_report;
    end
    initial begin
        void'($urandom(11006));
        step(10);
        rst = 0;
        rd(8'hd4, 8'h00);
        chk("wake_en", 1, wake_irq_enable);
        main_osc_tick = 1;
        count_pulses(c);
        chk("pulses", 4, c);
        for (int src = 0; src < 2; src++) begin
            osc_sub_select = src[0];
            for (int sel = 0; sel < 4; sel++) begin
                wr(8'hd4, {3'h0, sel[1:0], 3'h0});
                main_osc_tick = !src[0];
                sub_osc_tick = src[0];
                step($urandom % 5 + 2);
                count_pulses(c);
                chk("pulses", exp_pulses(sel[1:0]), c);
            end
            main_osc_tick = src[0];
            sub_osc_tick = !src[0];
            count_pulses(c);
            chk("no_pulse", 0, c);
        end
        repeat (6) begin
            d = 8'($urandom);
            wr(8'hd4, d);
            rd(8'hd4, d & 8'h98);
            chk("wake_en", !d[7], wake_irq_enable);
        end
        wr(8'hd4, 8'h80);
        wake_event = 1;
        step(2);
        chk("wake_req", 0, wake_irq_req_q);
        wr(8'hd4, 8'h00);
        chk("wake_req", 1, wake_irq_req_q);
        wake_event = 0;
        osc_sub_select = 0;
        main_osc_tick = 1;
        d = {4'($urandom), 4'hc};
        wr(8'hd3, d);
        step(100);
        chk("count_run", 1, bt_count_q != 0);
        wr(8'hd3, d | 8'h03);
        chk("count", 0, bt_count_q);
        chk("prescale_low", 1, tc_prescale < 12'h002);
        rd(8'hd3, d);
        step(8);
        chk("count_hold", 0, bt_count_q);
        step(40);
        c = bt_count_q;
        wr(8'hd3, d);
        chk("no_clear", 1, bt_count_q >= c && c > 0);
        for (int s = 0; s < 4; s++) begin
            wr(8'hd3, {4'h0, s[1:0], 2'h3});
            step((2 << exp_bt_log2(s[1:0])) - 1);
            chk("bt_count", 2, bt_count_q);
            chk("prescale", 16'((2 << exp_bt_log2(s[1:0])) % 4096), tc_prescale);
        end
        rd(8'hd5, 8'h00);
        wr(8'hd5, 8'hff);
        rd(8'hd4, 8'h00);
        wr(8'hd4, 8'h98);
        rst = 1;
        step(2);
        rst = 0;
        rd(8'hd4, 8'h00);
        final_report;
    end
endmodule

// *** core/clock_prescaler.v ***
// Free running prescaler counter advanced by an oscillator tick.
// Assumes a synchronous clear and one clock domain.
`timescale 1ns/1ps
module clock_prescaler #(
    parameter WIDTH = 12
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Control
    input  wire             tick,
    input  wire             clear,
    // Count
    output reg  [WIDTH-1:0] count_q
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst || clear) begin
            count_q <= {WIDTH{1'b0}};
        end else if (tick) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// *** core/clock_select_defines.vh ***
// Constants for the system clock select and divider clear block.
// Assumes inclusion by bare name from the core design files.
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_BASIC_TIMER_CONTROL   8'hd3
`define ADDR_SYSTEM_CLOCK_CONTROL  8'hd4
`define ADDR_BASIC_TIMER_COUNT     8'hfd

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCC_WAKE_DISABLE_BIT       7
`define SCC_SEL_HI                 4
`define SCC_SEL_LO                 3
`define BTC_BT_SEL_HI              3
`define BTC_BT_SEL_LO              2
`define BTC_COUNTER_CLEAR_BIT      1
`define BTC_DIVIDER_CLEAR_BIT      0

// ----------------------------------------------------------------
// Reset values, clear value and write masks
// ----------------------------------------------------------------
`define SCC_RESET                  8'h00
`define BTC_RESET                  8'h00
`define COUNT_CLEAR_VALUE          8'h00
`define SCC_WRITE_MASK             8'h98
`define BTC_STORE_MASK             8'hfc

// ----------------------------------------------------------------
// Clock select codes and divide ratios as log2
// ----------------------------------------------------------------
`define CPU_SEL_DIV16              2'h0
`define CPU_SEL_DIV8               2'h1
`define CPU_SEL_DIV2               2'h2
`define CPU_SEL_DIV1               2'h3
`define BT_SEL_DIV4096             2'h0
`define BT_SEL_DIV1024             2'h1
`define BT_SEL_DIV128              2'h2
`define BT_SEL_DIV16               2'h3
`define LOG2_DIV16                 4'h4
`define LOG2_DIV8                  4'h3
`define LOG2_DIV2                  4'h1
`define LOG2_DIV1                  4'h0
`define LOG2_DIV4096               4'hc
`define LOG2_DIV1024               4'ha
`define LOG2_DIV128                4'h7

`endif

// *** core/system_clock_divider_select.v ***
// System clock select, wake-up gate and basic timer divider clearing.
// Assumes register access by address with a one-cycle read latency.
//
// Behaviour
// - Bit 7 set blocks wake-up interrupt request
// - Select field picks divide by 16, 8, 2, 1
// - Reset selects divide by sixteen until written
// - Divided source is selected main or sub oscillator
// - Writing one to bit 1 clears counter
// - Counter clear bit returns to zero itself
// - Writing one to bit 0 clears divider
// - Divider clear self-clears; writing zero does nothing
// - Divider clear hits both timer dividers together
`timescale 1ns/1ps
`include "clock_select_defines.vh"
module system_clock_divider_select #(
    parameter DIV_WIDTH = 12,
    parameter CNT_WIDTH = 8
) (
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 rst,
    // Register access
    input  wire [7:0]           reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_we,
    input  wire                 reg_re,
    output reg  [7:0]           reg_rdata_q,
    // Oscillator sources
    input  wire                 main_osc_tick,
    input  wire                 sub_osc_tick,
    input  wire                 osc_sub_select,
    // Clock outputs
    output reg                  cpu_clk_en_q,
    output reg                  bt_clk_en_q,
    output wire [DIV_WIDTH-1:0] tc_prescale,
    output reg  [CNT_WIDTH-1:0] bt_count_q,
    // Wake-up
    input  wire                 wake_event,
    output reg                  wake_irq_req_q,
    output wire                 wake_irq_enable
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function tap_hit;
        input [DIV_WIDTH-1:0] cnt;
        input [3:0]           log2n;
        reg   [DIV_WIDTH-1:0] mask;
        begin
            mask    = ({{(DIV_WIDTH-1){1'b0}}, 1'b1} << log2n) - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
            tap_hit = &(cnt | ~mask);
        end
    endfunction

    function [3:0] cpu_log2;
        input [1:0] sel;
        begin
            case (sel)
                `CPU_SEL_DIV16: cpu_log2 = `LOG2_DIV16;
                `CPU_SEL_DIV8:  cpu_log2 = `LOG2_DIV8;
                `CPU_SEL_DIV2:  cpu_log2 = `LOG2_DIV2;
                default:        cpu_log2 = `LOG2_DIV1;
            endcase
        end
    endfunction

    function [3:0] bt_log2;
        input [1:0] sel;
        begin
            case (sel)
                `BT_SEL_DIV4096: bt_log2 = `LOG2_DIV4096;
                `BT_SEL_DIV1024: bt_log2 = `LOG2_DIV1024;
                `BT_SEL_DIV128:  bt_log2 = `LOG2_DIV128;
                default:         bt_log2 = `LOG2_DIV16;
            endcase
        end
    endfunction

    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]           sys_clk_ctrl_q;
    reg  [7:0]           bt_ctrl_q;
    wire                 fxx_tick;
    wire                 wr_scc;
    wire                 wr_btc;
    wire                 counter_clear;
    wire                 divider_clear;
    wire [1:0]           cpu_sel;
    wire [1:0]           bt_sel;
    wire [DIV_WIDTH-1:0] cpu_div;
    wire [DIV_WIDTH-1:0] bt_div;
    wire                 bt_tick;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    assign wr_scc = reg_we && addr_hit(reg_addr, `ADDR_SYSTEM_CLOCK_CONTROL);
    assign wr_btc = reg_we && addr_hit(reg_addr, `ADDR_BASIC_TIMER_CONTROL);

    // Strobes last only the write cycle
    assign counter_clear = wr_btc && reg_wdata[`BTC_COUNTER_CLEAR_BIT];
    assign divider_clear = wr_btc && reg_wdata[`BTC_DIVIDER_CLEAR_BIT];

    always @(posedge clk_sys) begin
        if (rst) begin
            sys_clk_ctrl_q <= `SCC_RESET;
            bt_ctrl_q      <= `BTC_RESET;
        end else begin
            if (wr_scc) begin
                sys_clk_ctrl_q <= reg_wdata & `SCC_WRITE_MASK;
            end
            if (wr_btc) begin
                // Strobe bits are never stored
                bt_ctrl_q <= reg_wdata & `BTC_STORE_MASK;
            end
        end
    end

    assign cpu_sel = sys_clk_ctrl_q[`SCC_SEL_HI:`SCC_SEL_LO];
    assign bt_sel  = bt_ctrl_q[`BTC_BT_SEL_HI:`BTC_BT_SEL_LO];

    // ------------------------------------------------------------
    // Oscillator selection
    // ------------------------------------------------------------
    assign fxx_tick = osc_sub_select ? sub_osc_tick : main_osc_tick;

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    clock_prescaler #(
        .WIDTH (DIV_WIDTH)
    ) u_cpu_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (fxx_tick),
        .clear   (1'b0),
        .count_q (cpu_div)
    );

    clock_prescaler #(
        .WIDTH (DIV_WIDTH)
    ) u_bt_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (fxx_tick),
        .clear   (divider_clear),
        .count_q (bt_div)
    );

    clock_prescaler #(
        .WIDTH (DIV_WIDTH)
    ) u_tc_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (fxx_tick),
        .clear   (divider_clear),
        .count_q (tc_prescale)
    );

    // ------------------------------------------------------------
    // Basic timer tick
    // ------------------------------------------------------------
    assign bt_tick = fxx_tick && !divider_clear && tap_hit(bt_div, bt_log2(bt_sel));

    // ------------------------------------------------------------
    // Clock enables and basic timer counter
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            cpu_clk_en_q <= 1'b0;
            bt_clk_en_q  <= 1'b0;
            bt_count_q   <= {CNT_WIDTH{1'b0}};
        end else begin
            cpu_clk_en_q <= fxx_tick && tap_hit(cpu_div, cpu_log2(cpu_sel));
            bt_clk_en_q  <= bt_tick;
            // Clear wins over a timer tick
            if (counter_clear) begin
                bt_count_q <= `COUNT_CLEAR_VALUE;
            end else if (bt_tick) begin
                bt_count_q <= bt_count_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Wake-up gate
    // ------------------------------------------------------------
    assign wake_irq_enable = !sys_clk_ctrl_q[`SCC_WAKE_DISABLE_BIT];

    always @(posedge clk_sys) begin
        if (rst) begin
            wake_irq_req_q <= 1'b0;
        end else begin
            wake_irq_req_q <= wake_event && wake_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                `ADDR_SYSTEM_CLOCK_CONTROL: reg_rdata_q <= sys_clk_ctrl_q;
                `ADDR_BASIC_TIMER_CONTROL:  reg_rdata_q <= bt_ctrl_q;
                `ADDR_BASIC_TIMER_COUNT:    reg_rdata_q <= bt_count_q[7:0];
                default:                    reg_rdata_q <= 8'h00;
            endcase
        end
    end
endmodule
